// file: rtl/ppp_port.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_port
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Host I/O bus
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   output logic      [7:0] io_rdata,
   // Printer data lines
   output logic      [7:0] data_out_lines,
   output logic            data_out_oe,
   // Printer status inputs
   input  wire logic [3:0] status_in_nibble,
   // Printer control outputs
   output logic      [3:0] control_out_nibble,
   output logic            control_out_oe,
   output logic            data_strobe_out,
   output logic            printer_init_out,
   // Adapter power lines
   output logic      [7:0] adapter_power_lines,
   output logic            adapter_power_oe
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] p);
      hit = (a == p);
   endfunction

   logic       wr_data;                             // Data port write
   logic       wr_hs;                               // Handshake write
   logic       wr_cfg;                              // Control write
   logic       wr_pwr;                              // Power port write
   logic       is_mode;                             // Mode select byte
   logic       is_sr;                               // Valid set/reset code
   logic [1:0] sr_sel;                              // Selected high bit
   logic [3:0] status_sync;                         // Synchronised status

   assign wr_data = io_wr && hit(io_addr, ppp_pkg::ADDR_DATA);
   assign wr_hs   = io_wr && hit(io_addr, ppp_pkg::ADDR_HANDSHAKE);
   assign wr_cfg  = io_wr && hit(io_addr, ppp_pkg::ADDR_CONFIG);
   assign wr_pwr  = io_wr && hit(io_addr, ppp_pkg::ADDR_POWER);
   assign is_mode = io_wdata[ppp_pkg::CFG_MODE_BIT];
   assign is_sr   = (io_wdata[7:4] == ppp_pkg::SR_TAG)
                    && io_wdata[3];
   assign sr_sel  = io_wdata[ppp_pkg::SR_SEL_MSB:ppp_pkg::SR_SEL_LSB];

   // ----------------------------------------------------------------
   // Status input synchroniser
   // ----------------------------------------------------------------
   ppp_sync ppp_sync_inst
   (
      .clk      (clk),
      .reset    (reset),
      .async_in (status_in_nibble),
      .sync_out (status_sync)
   );

   // ----------------------------------------------------------------
   // Direction configuration
   // ----------------------------------------------------------------
   logic       configured_reg;                      // Config byte seen
   logic       data_in_reg;                         // Data port is input
   logic       hi_in_reg;                           // High nibble input
   logic       pwr_in_reg;                          // Power port input
   logic       lo_in_reg;                           // Low nibble input

   // Mode select bytes at the control address set directions
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         configured_reg <= 1'b0;
         data_in_reg    <= 1'b1;
         hi_in_reg      <= 1'b1;
         pwr_in_reg     <= 1'b1;
         lo_in_reg      <= 1'b1;
      end
      else if (wr_cfg && is_mode)
      begin
         configured_reg <= 1'b1;
         data_in_reg    <= io_wdata[ppp_pkg::CFG_DATA_IN];
         hi_in_reg      <= io_wdata[ppp_pkg::CFG_HI_IN];
         pwr_in_reg     <= io_wdata[ppp_pkg::CFG_PWR_IN];
         lo_in_reg      <= io_wdata[ppp_pkg::CFG_LO_IN];
      end
   end

   assign data_out_oe      = configured_reg && !data_in_reg;
   assign control_out_oe   = configured_reg && !hi_in_reg;
   assign adapter_power_oe = configured_reg && !pwr_in_reg;

   // ----------------------------------------------------------------
   // Data and power output latches
   // ----------------------------------------------------------------
   logic [7:0] data_reg;                            // Printer data byte
   logic [7:0] pwr_reg;                             // Adapter power byte
   logic       data_busy;                           // Strobe guard active

   // Data byte written in order, bit 0 on lowest line
   always_ff @(posedge clk)
   begin
      if (reset)
         data_reg <= ppp_pkg::BYTE_ZERO;
      else if (wr_data && !data_busy)
         data_reg <= io_wdata;
   end

   // Power byte latch
   always_ff @(posedge clk)
   begin
      if (reset)
         pwr_reg <= ppp_pkg::BYTE_ZERO;
      else if (wr_pwr)
         pwr_reg <= io_wdata;
   end

   assign data_out_lines      = data_reg;
   assign adapter_power_lines = pwr_reg;

   // ----------------------------------------------------------------
   // High nibble set/reset
   // ----------------------------------------------------------------
   logic [3:0] hi_reg;                              // Requested levels
   logic       stb_req;                             // Host strobe request

   // Each set/reset byte at the handshake address moves one line
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            if (reset)
               hi_reg[gi] <= 1'b0;
            else if (wr_hs && is_sr && (sr_sel == 2'(gi)))
               hi_reg[gi] <= io_wdata[ppp_pkg::SR_LEVEL_BIT];
         end
      end
   endgenerate

   assign stb_req = hi_reg[ppp_pkg::STB_BIT];

   // ----------------------------------------------------------------
   // Strobe guard: data settles before strobe, held while it is high
   // ----------------------------------------------------------------
   ppp_pkg::ppp_state_t state_reg;
   logic [1:0]          cnt_reg;                    // Setup countdown

   // Strobe rises only after data has stood for the setup time
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg <= ppp_pkg::PPP_IDLE;
         cnt_reg   <= ppp_pkg::CNT_ZERO;
      end
      else
      begin
         case (state_reg)
            ppp_pkg::PPP_IDLE:
            begin
               if (stb_req)
               begin
                  state_reg <= ppp_pkg::PPP_SETUP;
                  cnt_reg   <= ppp_pkg::SETUP_CNT;
               end
            end
            ppp_pkg::PPP_SETUP:
            begin
               if (!stb_req)
                  state_reg <= ppp_pkg::PPP_IDLE;
               else if (cnt_reg == ppp_pkg::CNT_ONE)
                  state_reg <= ppp_pkg::PPP_HOLD;
               else
                  cnt_reg <= cnt_reg - ppp_pkg::CNT_ONE;
            end
            ppp_pkg::PPP_HOLD:
            begin
               if (!stb_req)
                  state_reg <= ppp_pkg::PPP_IDLE;
            end
            default:
               state_reg <= ppp_pkg::PPP_IDLE;
         endcase
      end
   end

   // Data writes are ignored from the strobe request until strobe released
   assign data_busy = stb_req || (state_reg != ppp_pkg::PPP_IDLE);

   // Output nibble: strobe bit gated by guard
   always_comb
   begin
      control_out_nibble = hi_reg;
      control_out_nibble[ppp_pkg::STB_BIT] =
         (state_reg == ppp_pkg::PPP_HOLD);
   end

   assign data_strobe_out  = control_out_nibble[ppp_pkg::STB_BIT];
   assign printer_init_out = control_out_nibble[ppp_pkg::INIT_BIT];

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Handshake read: status low nibble when low nibble is input (else zero), high nibble output levels
   always_ff @(posedge clk)
   begin
      if (reset)
         io_rdata <= ppp_pkg::BYTE_ZERO;
      else if (io_rd && hit(io_addr, ppp_pkg::ADDR_HANDSHAKE))
         io_rdata <= {control_out_nibble,
                      lo_in_reg ? status_sync : ppp_pkg::NIB_ZERO};
      else
         io_rdata <= ppp_pkg::BYTE_ZERO;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_data_write;
      wr_data && !data_busy;
   endsequence

   sequence s_strobe_rise;
      !data_strobe_out ##1 data_strobe_out;
   endsequence

   a_data_latch: assert property (@(posedge clk) disable iff (reset)
      s_data_write |=> (data_out_lines == $past(io_wdata)))
      else $error("data byte not latched");

   a_data_stable: assert property (@(posedge clk) disable iff (reset)
      data_strobe_out |=> $stable(data_out_lines))
      else $error("data changed during strobe");

   a_strobe_setup: assert property (@(posedge clk) disable iff (reset)
      s_strobe_rise |-> $past(data_busy, 2))
      else $error("strobe rose without setup");

   a_cfg_dirs: assert property (@(posedge clk) disable iff (reset)
      (wr_cfg && io_wdata == ppp_pkg::CFG_PRINTER) |=>
      (data_out_oe && control_out_oe && adapter_power_oe && lo_in_reg))
      else $error("printer setup directions wrong");

   a_reset_hiz: assert property (@(posedge clk) disable iff (reset)
      !configured_reg |-> !(data_out_oe || control_out_oe
                            || adapter_power_oe))
      else $error("line driven before configuration");

   a_sr_level: assert property (@(posedge clk) disable iff (reset)
      (wr_hs && is_sr) |=>
      (hi_reg[$past(sr_sel)] == $past(io_wdata[ppp_pkg::SR_LEVEL_BIT])))
      else $error("set/reset level wrong");

   a_sr_single: assert property (@(posedge clk) disable iff (reset)
      (wr_hs && is_sr && sr_sel != 2'h1) |=>
      (hi_reg[1] == $past(hi_reg[1])))
      else $error("set/reset touched another line");

   a_init_pin: assert property (@(posedge clk) disable iff (reset)
      printer_init_out == hi_reg[ppp_pkg::INIT_BIT])
      else $error("init line mismatch");

   a_status_read: assert property (@(posedge clk) disable iff (reset)
      (io_rd && io_addr == ppp_pkg::ADDR_HANDSHAKE && lo_in_reg) |=>
      (io_rdata[3:0] == $past(status_sync)))
      else $error("status read wrong");

   a_data_refused: assert property (@(posedge clk) disable iff (reset)
      (wr_data && data_busy) |=> $stable(data_out_lines))
      else $error("data written while strobe guarded");

   a_strobe_release: assert property (@(posedge clk) disable iff (reset)
      (data_strobe_out && !stb_req) |=> !data_strobe_out)
      else $error("strobe not released");

   a_power_latch: assert property (@(posedge clk) disable iff (reset)
      wr_pwr |=> (adapter_power_lines == $past(io_wdata)))
      else $error("power byte not latched");

   a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
      !(io_rd && io_addr == ppp_pkg::ADDR_HANDSHAKE) |=>
      (io_rdata == ppp_pkg::BYTE_ZERO))
      else $error("read data not cleared");

endmodule
`default_nettype wire

// file: rtl/ppp_pkg.sv
package ppp_pkg;
   // ----------------------------------------------------------------
   // Port addresses on the host I/O bus
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_HANDSHAKE = 8'hE0;  // Status read, set/reset
   localparam logic [7:0] ADDR_CONFIG    = 8'hE1;  // Configuration byte
   localparam logic [7:0] ADDR_DATA      = 8'hE2;  // Printer data byte
   localparam logic [7:0] ADDR_POWER     = 8'hE3;  // Adapter power byte

   // ----------------------------------------------------------------
   // Configuration byte layout
   // ----------------------------------------------------------------
   localparam int         CFG_MODE_BIT  = 7;       // 1 = mode select byte
   localparam int         CFG_DATA_IN   = 4;       // Data port direction
   localparam int         CFG_HI_IN     = 3;       // High nibble direction
   localparam int         CFG_PWR_IN    = 5;       // Power dir, 0 in 87H
   localparam int         CFG_LO_IN     = 0;       // Low nibble direction
   localparam logic [7:0] CFG_PRINTER   = 8'h87;   // Standard printer setup

   // ----------------------------------------------------------------
   // Set/reset byte layout
   // ----------------------------------------------------------------
   localparam logic [3:0] SR_TAG        = 4'h0;    // Upper nibble of code
   localparam int         SR_SEL_LSB    = 1;       // Bit-select field
   localparam int         SR_SEL_MSB    = 2;
   localparam int         SR_LEVEL_BIT  = 0;       // New line level
   localparam int         HI_NIBBLE_LSB = 4;       // First controlled bit

   // ----------------------------------------------------------------
   // Reset values and strobe timing
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [3:0] NIB_ZERO      = 4'h0;
   localparam int         STB_BIT       = 0;       // Strobe within nibble
   localparam int         INIT_BIT      = 1;       // Init within nibble
   localparam int         SETUP_NS      = 80;      // Data before strobe
   localparam int         CLK_NS        = 40;
   localparam int         SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] SETUP_CNT     = 2'(SETUP_CYC);
   localparam logic [1:0] CNT_ZERO      = 2'h0;
   localparam logic [1:0] CNT_ONE       = 2'h1;

   // ----------------------------------------------------------------
   // Strobe guard states
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PPP_IDLE  = 2'b00,                            // Strobe released
      PPP_SETUP = 2'b01,                            // Data settling
      PPP_HOLD  = 2'b11                             // Strobe asserted
   } ppp_state_t;
endpackage

// file: rtl/ppp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_sync
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Asynchronous nibble in, synchronised nibble out
   input  wire logic [3:0] async_in,
   output logic      [3:0] sync_out
);

   logic [3:0] meta_reg;                           // First stage only

   // ----------------------------------------------------------------
   // Two flip-flop synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_reg <= ppp_pkg::NIB_ZERO;
         sync_out <= ppp_pkg::NIB_ZERO;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// file: bench/ppp_printer_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Line printer on the far side of the port
// ----------------------------------------------------------------
module ppp_printer_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Lines from the port
   input  wire logic [7:0] data_lines,
   input  wire logic       strobe,
   input  wire logic       init,
   // Error request from the bench
   input  wire logic       fault,
   // Status nibble back to the port
   output logic      [3:0] status,
   // Byte taken at strobe and count of data changes under strobe
   output logic      [7:0] latched_byte,
   output logic      [7:0] hold_errs
);
   logic       strobe_d;   // Strobe one cycle ago
   logic [2:0] busy_cnt;   // Cycles left until acknowledge ends

   // Takes the byte on strobe rise, counts changes while strobe high
   always_ff @(posedge clk)
   begin
      strobe_d <= strobe;
      if (reset)
      begin
         latched_byte <= 8'h00;
         hold_errs    <= 8'h00;
         busy_cnt     <= 3'h0;
      end
      else if (strobe && !strobe_d)
      begin
         latched_byte <= data_lines;
         busy_cnt     <= 3'h5;
      end
      else
      begin
         if (strobe && data_lines != latched_byte)
            hold_errs <= hold_errs + 8'h01;
         if (busy_cnt != 3'h0)
            busy_cnt <= busy_cnt - 3'h1;
      end
   end

   // Error, acknowledge, not ready, online; offline while initialising
   assign status = {fault, busy_cnt == 3'h1, busy_cnt != 3'h0, ~init};
endmodule
`default_nettype wire

// file: bench/test_printer_parallel_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_printer_parallel_port;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic       clk = 1'b0;           // Bus clock
   logic       reset;                // Synchronous reset
   logic [7:0] io_addr, io_wdata;    // Host bus request
   logic       io_wr, io_rd;         // Host bus strobes
   logic [7:0] io_rdata;             // Read answer
   logic [7:0] data_out_lines, adapter_power_lines;
   logic       data_out_oe, control_out_oe, adapter_power_oe;
   logic [3:0] control_out_nibble;   // High handshake levels
   logic       data_strobe_out, printer_init_out;
   logic [3:0] status_in_nibble;     // From the printer
   logic       fault;                // Printer error request
   logic [7:0] latched_byte, hold_errs, rd, code;
   logic [7:0] wire_data;            // Data as the printer sees it
   logic [2:0] oe_bits;              // Enables: data, control, power
   int         bad_count = 0;
   int         num_checks = 0;

   always #20 clk = ~clk;

   // Released lines show the inverse of the last value
   assign wire_data = data_out_oe ? data_out_lines : ~data_out_lines;
   assign oe_bits   = {data_out_oe, control_out_oe, adapter_power_oe};

   ppp_port ppp_port_inst (.clk(clk), .reset(reset), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
      .io_rdata(io_rdata), .data_out_lines(data_out_lines),
      .data_out_oe(data_out_oe), .status_in_nibble(status_in_nibble),
      .control_out_nibble(control_out_nibble),
      .control_out_oe(control_out_oe), .data_strobe_out(data_strobe_out),
      .printer_init_out(printer_init_out),
      .adapter_power_lines(adapter_power_lines),
      .adapter_power_oe(adapter_power_oe));

   ppp_printer_model ppp_printer_model_inst (.clk(clk), .reset(reset),
      .data_lines(wire_data), .strobe(data_strobe_out & control_out_oe),
      .init(printer_init_out & control_out_oe), .fault(fault),
      .status(status_in_nibble), .latched_byte(latched_byte),
      .hold_errs(hold_errs));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      io_addr  = a;
      io_wdata = d;
      io_wr    = 1'b1;
      tick(1);
      io_wr    = 1'b0;
   endtask

   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      tick(1);
      io_addr = a;
      io_rd   = 1'b1;
      tick(1);
      io_rd   = 1'b0;
      d       = io_rdata;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog cuts a hang short
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      fault = 1'b0;
      tick(16);
      reset = 1'b0;
      tick(2);
      check(8'h00, {5'h00, oe_bits});
      // Lines are inputs: online status already readable
      io_read(8'hE0, rd);
      check(8'h01, rd);
      io_write(8'hE1, 8'h07);
      check(8'h00, {5'h00, oe_bits});
      io_write(8'hE1, 8'h87);
      check(8'h07, {5'h00, oe_bits});
      io_write(8'hE2, 8'h55);
      check(8'h55, wire_data);
      io_write(8'hE3, 8'hA5);
      check(8'hA5, adapter_power_lines);
      // Set/reset code at the control address, then a foreign code
      io_write(8'hE1, 8'h0B);
      tick(3);
      check(8'h00, {4'h0, control_out_nibble});
      io_write(8'hE0, 8'h13);
      tick(3);
      check(8'h00, {4'h0, control_out_nibble});
      // Set and reset each non-strobe line
      for (int i = 1; i < 4; i++)
      begin
         code = 8'h09 + 8'(2 * i);
         io_write(8'hE0, code);
         check((8'h01 << i) | ((i == 1) ? 8'h10 : 8'h00),
               {3'h0, printer_init_out, control_out_nibble});
         io_write(8'hE0, code - 8'h01);
         check(8'h00, {3'h0, printer_init_out, control_out_nibble});
      end
      // Status with init high and printer error
      io_write(8'hE0, 8'h0B);
      fault = 1'b1;
      tick(4);
      io_read(8'hE0, rd);
      check(8'h28, rd);
      io_write(8'hE0, 8'h0A);
      fault = 1'b0;
      tick(4);
      io_read(8'hE0, rd);
      check(8'h01, rd);
      // Strobe after data setup, data write refused meanwhile
      io_write(8'hE2, 8'h3C);
      io_write(8'hE0, 8'h09);
      tick(2);
      check(8'h00, {7'h00, data_strobe_out});
      tick(1);
      check(8'h01, {7'h00, data_strobe_out});
      io_write(8'hE2, 8'hFF);
      check(8'h3C, wire_data);
      io_write(8'hE0, 8'h08);
      tick(1);
      check(8'h00, {7'h00, data_strobe_out});
      check(8'h3C, latched_byte);
      check(8'h00, hold_errs);
      tick(2);
      io_write(8'hE2, 8'hC3);
      check(8'hC3, wire_data);
      io_read(8'h55, rd);
      check(8'h00, rd);
      // Data and high nibble as inputs, low nibble as output
      io_write(8'hE1, 8'h98);
      check(8'h01, {5'h00, oe_bits});
      io_read(8'hE0, rd);
      check(8'h00, rd);
      tally_and_finish();
   end
endmodule
`default_nettype wire
